// file: rtl/rpfb_pkg.sv
// Purpose: shared constants and carriers of the packet framer and buffers
// Assumes: 125 MHz system clock, byte-wide symbol stream towards the modem
// Notes:   register offsets are byte addresses on a 32-bit Avalon-MM slave
package rpfb_pkg;
    // clock and air timing
    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned CLK_NS       = 8;
    localparam int unsigned GFSK_BYTE_NS = 8_000;   // 8 bits at 1 Mbps
    localparam int unsigned PN32_BYTE_NS = 32_000;  // one 32-chip symbol
    localparam int unsigned PN64_BYTE_NS = 64_000;  // one 64-chip symbol
    localparam int unsigned GFSK_CYC     = GFSK_BYTE_NS / CLK_NS;
    localparam int unsigned PN32_CYC     = PN32_BYTE_NS / CLK_NS;
    localparam int unsigned PN64_CYC     = PN64_BYTE_NS / CLK_NS;
    // buffered clock output, half periods rounded down
    localparam int unsigned XO_HZ0 = 750_000;
    localparam int unsigned XO_HZ1 = 1_500_000;
    localparam int unsigned XO_HZ2 = 3_000_000;
    localparam int unsigned XO_HZ3 = 6_000_000;
    localparam int unsigned XO_HZ4 = 12_000_000;
    localparam logic [6:0] XO_HALF0 = 7'(CLK_HZ / (2 * XO_HZ0));
    localparam logic [6:0] XO_HALF1 = 7'(CLK_HZ / (2 * XO_HZ1));
    localparam logic [6:0] XO_HALF2 = 7'(CLK_HZ / (2 * XO_HZ2));
    localparam logic [6:0] XO_HALF3 = 7'(CLK_HZ / (2 * XO_HZ3));
    localparam logic [6:0] XO_HALF4 = 7'(CLK_HZ / (2 * XO_HZ4));
    // buffers and framing
    localparam int unsigned BUF_DEPTH  = 16;
    localparam int unsigned MAX_PKT    = 40;
    localparam logic [15:0] CRC_POLY   = 16'h8005;  // x16+x15+x2+1
    localparam logic [15:0] SEED_RST   = 16'h0000;
    localparam logic [7:0]  ACK_LEN    = 8'h00;
    // register map
    localparam logic [4:0] REG_CTRL   = 5'h00;
    localparam logic [4:0] REG_SEED   = 5'h04;
    localparam logic [4:0] REG_TXLEN  = 5'h08;
    localparam logic [4:0] REG_GO     = 5'h0C;
    localparam logic [4:0] REG_TXDATA = 5'h10;
    localparam logic [4:0] REG_RXDATA = 5'h14;
    localparam logic [4:0] REG_STATUS = 5'h18;
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    // status fields
    localparam int unsigned ST_DONE = 0;
    localparam int unsigned ST_CRCE = 1;
    localparam int unsigned ST_OVFL = 2;
    localparam int unsigned ST_BUSY = 3;

    typedef enum logic [1:0] {XF_CLOCK = 2'h0, XF_EXT_AMP_CONTROL = 2'h1, XF_GPIO = 2'h2} rpfb_xfn_e;
    typedef enum logic [2:0] {
        F_IDLE = 3'b000, F_SOP = 3'b001, F_LEN = 3'b011, F_PAY = 3'b010, F_CRC = 3'b110
    } rpfb_fsm_e;

    typedef struct packed {
        logic       sop_pn64;   // start marker code length
        logic       gpio;       // level for gpio use of pins
        logic [2:0] clk_sel;    // 0..4 : 0.75 .. 12 MHz
        rpfb_xfn_e  xfn;        // clock output pin function
        logic       sleep;
        logic       three_wire;
        logic       ack_en;
        logic       seed_zero;  // transmit crc from zero seed
        logic       crc_en;
        logic       pn64;       // body code length in spread mode
        logic       spread;     // eight-bit-per-symbol mode
        logic       rsvd;
    } rpfb_ctrl_s;

    typedef struct packed {
        logic       valid;
        logic       sop;
        logic       spread;
        logic       pn64;
        logic [7:0] data;
    } rpfb_txsym_s;

    typedef struct packed {
        logic       valid;
        logic       sop;
        logic [7:0] data;
    } rpfb_rxsym_s;
endpackage

// file: rtl/rpfb_framer.sv
// Purpose: packet framer with 16-byte transmit and receive buffers
// Assumes: modem delivers and takes one byte-symbol per strobe; pins synchronous
// Notes:   Avalon-MM slave with one wait state on every access
// Functional notes
// - serial data output tristates when three-wire select is 0 and select is high
// - clock pin gives 0.75..12 MHz, amplifier control or gpio; tristates in sleep
// - gfsk mode sends at 1 Mbps with no spreading
// - spread mode maps each eight data bits onto one code symbol
// - spread mode offers 64-chip or 32-chip codes
// - every packet opens with two start symbols on their own code
// - both link ends use the same start marker code length
// - an eight-bit length byte follows the start marker at payload rate
// - receiver ends packet after length bytes plus two crc bytes, or plus one byte with crc disabled
// - transmitter appends a 16-bit crc when enabled
// - crc uses the usb crc16 polynomial with a programmable seed
// - transmitted crc starts from loaded seed or zero, as configured
// - receiver checks crc against both configured seed and zero seed
// - receiver takes packets of any rate without rate setup
// - with auto ack on, an ack packet follows each valid received packet with a nonzero length byte
// - separate 16-byte transmit and receive buffers
// - one burst fills the transmit buffer, then it sends unaided
// - packets up to 40 bytes are supported
// - buffer level flags let the host stream longer packets
// - ack packets leave both buffers untouched
`timescale 1ns/1ps
`default_nettype none
module rpfb_framer #(
    parameter int unsigned GFSK_TICKS = rpfb_pkg::GFSK_CYC,
    parameter int unsigned PN32_TICKS = rpfb_pkg::PN32_CYC,
    parameter int unsigned PN64_TICKS = rpfb_pkg::PN64_CYC
) (
    // clock and reset
    input  wire logic              I_CLOCK,
    input  wire logic              I_RST_N,
    // avalon-mm register slave
    input  wire logic [4:0]        I_AVS_ADDRESS,
    input  wire logic              I_AVS_READ,
    input  wire logic              I_AVS_WRITE,
    input  wire logic [31:0]       I_AVS_WRITEDATA,
    input  wire logic [3:0]        I_AVS_BYTEENABLE,
    output logic      [31:0]       O_AVS_READDATA,
    output logic                   O_AVS_WAITREQUEST,
    // serial data pin
    input  wire logic              I_SS_N,
    input  wire logic              I_SPI_DOUT,
    output logic                   O_MISO,
    output logic                   O_MISO_OE,
    // clock output pin
    output logic                   O_CLKOUT,
    output logic                   O_CLKOUT_OE,
    // modem symbol stream
    output rpfb_pkg::rpfb_txsym_s  O_TX_SYM,
    input  wire rpfb_pkg::rpfb_rxsym_s I_RX_SYM,
    // buffer level flags and transmit busy flag
    output logic                   O_TX_ROOM,
    output logic                   O_RX_READY,
    output logic                   O_TX_BUSY
);
    import rpfb_pkg::*;

    typedef struct packed {
        rpfb_ctrl_s            ctrl;
        logic [15:0]           seed;
        logic [7:0]            tx_len;
        logic                  ack_q;
        logic [31:0]           rdata;
        logic [15:0][7:0]      tx_mem;
        logic [3:0]            tx_wp;
        logic [3:0]            tx_rp;
        logic [4:0]            tx_n;
        logic [15:0][7:0]      rx_mem;
        logic [3:0]            rx_wp;
        logic [3:0]            rx_rp;
        logic [4:0]            rx_n;
        rpfb_fsm_e             tx_st;
        logic [7:0]            tx_cnt;
        logic                  tx_ack;
        logic [13:0]           tick;
        logic [15:0]           tx_crc;
        rpfb_txsym_s           sym;
        rpfb_fsm_e             rx_st;
        logic [7:0]            rx_len;
        logic [7:0]            rx_cnt;
        logic [15:0]           crc_s;
        logic [15:0]           crc_z;
        logic [15:0]           rx_fcs;
        logic                  ack_req;
        logic [2:0]            stat;  // done, crc error, overflow
        logic [6:0]            xo_cnt;
        logic                  xo;
    } rpfb_state_s;

    rpfb_state_s s;
    rpfb_state_s next_s;

    ////////////////////////////////////////////////////////////////////////
    // crc16 over one byte, msb first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    // symbol period for the code in use
    function automatic logic [13:0] sym_ticks(input logic spr, input logic p64);
        if (!spr) begin
            return 14'(GFSK_TICKS - 1);
        end
        return p64 ? 14'(PN64_TICKS - 1) : 14'(PN32_TICKS - 1);
    endfunction

    function automatic logic [6:0] xo_half(input logic [2:0] sel);
        case (sel)
            3'h0:    return XO_HALF0;
            3'h1:    return XO_HALF1;
            3'h2:    return XO_HALF2;
            3'h3:    return XO_HALF3;
            default: return XO_HALF4;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus decode: request accepted on its second cycle
    logic req;
    logic acc;
    logic wr_acc;
    logic tx_push;
    logic rx_pop;
    logic tx_pop;
    logic rx_push;
    logic tick_hit;
    logic [15:0] wmask;

    assign req     = I_AVS_READ | I_AVS_WRITE;
    assign acc     = req & s.ack_q;
    assign wr_acc  = acc & I_AVS_WRITE;
    assign wmask   = {{8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};
    assign tx_push = wr_acc && I_AVS_ADDRESS == REG_TXDATA && I_AVS_BYTEENABLE[0]
                     && s.tx_n != 5'(BUF_DEPTH);
    assign rx_pop  = acc && I_AVS_READ && I_AVS_ADDRESS == REG_RXDATA && s.rx_n != 5'h00;
    assign tick_hit = s.tick == 14'h0000;
    // payload bytes leave the buffer only on a data packet, never on an ack
    assign tx_pop  = s.tx_st == F_PAY && tick_hit && !s.tx_ack && s.tx_n != 5'h00;
    assign rx_push = s.rx_st == F_PAY && I_RX_SYM.valid && !I_RX_SYM.sop
                     && s.rx_n != 5'(BUF_DEPTH) && s.tx_st == F_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_s = s;
        next_s.sym.valid = 1'b0;
        // bus handshake and read data
        next_s.ack_q = req & ~s.ack_q;
        if (req && !s.ack_q) begin
            case (I_AVS_ADDRESS)
                REG_CTRL:   next_s.rdata = {17'h00000, s.ctrl};
                REG_SEED:   next_s.rdata = {16'h0000, s.seed};
                REG_TXLEN:  next_s.rdata = {24'h000000, s.tx_len};
                REG_RXDATA: next_s.rdata = {24'h000000, s.rx_mem[s.rx_rp]};
                REG_STATUS: next_s.rdata = {4'h0, s.rx_len, 3'h0, s.rx_n, 3'h0, s.tx_n,
                                            (s.tx_st != F_IDLE), s.stat};
                default:    next_s.rdata = 32'h00000000;
            endcase
        end
        if (wr_acc) begin
            case (I_AVS_ADDRESS)
                REG_CTRL:   next_s.ctrl = (s.ctrl & ~wmask[14:0])
                                          | (I_AVS_WRITEDATA[14:0] & wmask[14:0]);
                REG_SEED:   next_s.seed = (s.seed & ~wmask) | (I_AVS_WRITEDATA[15:0] & wmask);
                REG_TXLEN:  next_s.tx_len = I_AVS_BYTEENABLE[0] ? I_AVS_WRITEDATA[7:0] : s.tx_len;
                REG_STATUS: next_s.stat = s.stat & ~I_AVS_WRITEDATA[2:0];
                default:    next_s.stat = next_s.stat;
            endcase
        end
        // transmit buffer
        if (tx_push) begin
            next_s.tx_mem[s.tx_wp] = I_AVS_WRITEDATA[7:0];
            next_s.tx_wp = s.tx_wp + 4'h1;
        end
        if (tx_pop) begin
            next_s.tx_rp = s.tx_rp + 4'h1;
        end
        next_s.tx_n = s.tx_n + {4'h0, tx_push} - {4'h0, tx_pop};
        // receive buffer
        if (rx_push) begin
            next_s.rx_mem[s.rx_wp] = I_RX_SYM.data;
            next_s.rx_wp = s.rx_wp + 4'h1;
        end
        if (rx_pop) begin
            next_s.rx_rp = s.rx_rp + 4'h1;
        end
        next_s.rx_n = s.rx_n + {4'h0, rx_push} - {4'h0, rx_pop};

        // transmit framer, one symbol per tick
        if (s.tx_st != F_IDLE) begin
            next_s.tick = tick_hit ? s.tick : s.tick - 14'h0001;
        end
        case (s.tx_st)
            F_IDLE: begin
                if (s.ack_req || (wr_acc && I_AVS_ADDRESS == REG_GO && I_AVS_WRITEDATA[0])) begin
                    next_s.tx_st = F_SOP;
                    next_s.tx_ack = s.ack_req;
                    next_s.ack_req = 1'b0;
                    next_s.tx_cnt = 8'h00;
                    next_s.tick = 14'h0000;
                    next_s.tx_crc = s.ctrl.seed_zero ? 16'h0000 : s.seed;
                end
            end
            F_SOP: begin
                if (tick_hit) begin
                    // start marker on its own code length
                    next_s.sym = '{1'b1, 1'b1, s.ctrl.spread, s.ctrl.sop_pn64, 8'h00};
                    next_s.tick = sym_ticks(s.ctrl.spread, s.ctrl.sop_pn64);
                    next_s.tx_cnt = s.tx_cnt + 8'h01;
                    if (s.tx_cnt == 8'h01) begin
                        next_s.tx_st = F_LEN;
                        next_s.tx_cnt = 8'h00;
                    end
                end
            end
            F_LEN, F_PAY: begin
                if (tick_hit && (s.tx_st == F_LEN || s.tx_ack || s.tx_n != 5'h00)) begin
                    // length and payload at the body rate
                    next_s.sym.valid = 1'b1;
                    next_s.sym.sop = 1'b0;
                    next_s.sym.spread = s.ctrl.spread;
                    next_s.sym.pn64 = s.ctrl.pn64;
                    next_s.sym.data = (s.tx_st == F_LEN) ? (s.tx_ack ? ACK_LEN : s.tx_len)
                                      : s.tx_mem[s.tx_rp];
                    next_s.tick = sym_ticks(s.ctrl.spread, s.ctrl.pn64);
                    next_s.tx_crc = crc_byte(s.tx_crc, next_s.sym.data);
                    next_s.tx_cnt = (s.tx_st == F_LEN) ? 8'h00 : s.tx_cnt + 8'h01;
                    if ((s.tx_st == F_LEN && (s.tx_ack || s.tx_len == 8'h00))
                        || (s.tx_st == F_PAY && s.tx_cnt + 8'h01 == s.tx_len)) begin
                        next_s.tx_st = s.ctrl.crc_en ? F_CRC : F_IDLE;
                        next_s.tx_cnt = 8'h00;
                    end else begin
                        next_s.tx_st = F_PAY;
                    end
                end
            end
            F_CRC: begin
                if (tick_hit) begin
                    next_s.sym.valid = 1'b1;
                    next_s.sym.sop = 1'b0;
                    next_s.sym.data = (s.tx_cnt == 8'h00) ? s.tx_crc[15:8] : s.tx_crc[7:0];
                    next_s.tick = sym_ticks(s.ctrl.spread, s.ctrl.pn64);
                    next_s.tx_cnt = s.tx_cnt + 8'h01;
                    if (s.tx_cnt == 8'h01) begin
                        next_s.tx_st = F_IDLE;
                    end
                end
            end
            default: next_s.tx_st = F_IDLE;
        endcase

        // receive framer, paced by the modem strobe so any rate is taken
        if (I_RX_SYM.valid && s.tx_st == F_IDLE) begin
            case (s.rx_st)
                F_IDLE: begin
                    if (I_RX_SYM.sop) begin
                        next_s.rx_st = F_SOP;
                    end
                end
                F_SOP: begin
                    next_s.rx_st = I_RX_SYM.sop ? F_LEN : F_IDLE;
                end
                F_LEN: begin
                    next_s.rx_len = I_RX_SYM.data;
                    next_s.rx_cnt = 8'h00;
                    next_s.crc_s = crc_byte(s.seed, I_RX_SYM.data);
                    next_s.crc_z = crc_byte(16'h0000, I_RX_SYM.data);
                    next_s.rx_st = (I_RX_SYM.data == 8'h00) ? F_CRC : F_PAY;
                end
                F_PAY: begin
                    if (s.rx_n == 5'(BUF_DEPTH) && !rx_pop) begin
                        next_s.stat[ST_OVFL] = 1'b1;
                    end
                    next_s.crc_s = crc_byte(s.crc_s, I_RX_SYM.data);
                    next_s.crc_z = crc_byte(s.crc_z, I_RX_SYM.data);
                    next_s.rx_cnt = s.rx_cnt + 8'h01;
                    if (s.rx_cnt + 8'h01 == s.rx_len) begin
                        next_s.rx_st = F_CRC;
                        next_s.rx_cnt = 8'h00;
                    end
                end
                F_CRC: begin
                    // end of packet inferred from length plus two crc bytes, or one byte when crc is off
                    next_s.rx_fcs = {s.rx_fcs[7:0], I_RX_SYM.data};
                    next_s.rx_cnt = s.rx_cnt + 8'h01;
                    if (s.rx_cnt == 8'h01 || !s.ctrl.crc_en) begin
                        next_s.rx_st = F_IDLE;
                        next_s.stat[ST_DONE] = s.rx_len != 8'h00;
                        if (s.ctrl.crc_en && {s.rx_fcs[7:0], I_RX_SYM.data} != s.crc_s
                            && {s.rx_fcs[7:0], I_RX_SYM.data} != s.crc_z) begin
                            next_s.stat[ST_CRCE] = 1'b1;
                        end else if (s.ctrl.ack_en && s.rx_len != 8'h00) begin
                            next_s.ack_req = 1'b1;
                        end
                    end
                end
                default: next_s.rx_st = F_IDLE;
            endcase
        end

        // buffered clock divider
        if (s.xo_cnt == 7'h00) begin
            next_s.xo_cnt = xo_half(s.ctrl.clk_sel) - 7'h01;
            next_s.xo = ~s.xo;
        end else begin
            next_s.xo_cnt = s.xo_cnt - 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign O_AVS_WAITREQUEST = req & ~s.ack_q;
    assign O_AVS_READDATA    = s.rdata;
    assign O_TX_SYM          = s.sym;
    assign O_TX_ROOM         = s.tx_n != 5'(BUF_DEPTH);
    assign O_RX_READY        = s.rx_n != 5'h00;
    assign O_TX_BUSY         = s.tx_st != F_IDLE;
    // gpio level in three-wire mode, else the serial engine's data
    assign O_MISO            = s.ctrl.three_wire ? s.ctrl.gpio : I_SPI_DOUT;
    assign O_MISO_OE         = s.ctrl.three_wire | ~I_SS_N;
    assign O_CLKOUT_OE       = ~s.ctrl.sleep;
    assign O_CLKOUT          = (s.ctrl.xfn == XF_CLOCK) ? s.xo
                             : (s.ctrl.xfn == XF_EXT_AMP_CONTROL) ? (s.tx_st != F_IDLE) : s.ctrl.gpio;

    ////////////////////////////////////////////////////////////////////////
    // checks
    miso_tristate_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (!s.ctrl.three_wire && I_SS_N) |-> !O_MISO_OE)
        else $error("serial data pin driven while deselected");
    clkout_sleep_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        s.ctrl.sleep |-> !O_CLKOUT_OE)
        else $error("clock pin driven in sleep");
    gfsk_plain_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (O_TX_SYM.valid && !s.ctrl.spread && !O_TX_SYM.sop) |-> !O_TX_SYM.spread)
        else $error("spreading in gfsk mode");
    sop_then_len_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (s.tx_st == F_SOP && next_s.tx_st == F_LEN) |=> (O_TX_SYM.valid && O_TX_SYM.sop))
        else $error("start marker not sent before length");
    rx_overflow_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (s.rx_st == F_PAY && I_RX_SYM.valid && !I_RX_SYM.sop && s.tx_st == F_IDLE
         && s.rx_n == 5'(BUF_DEPTH) && !rx_pop) |=> s.stat[ST_OVFL])
        else $error("overflow not flagged");
    ack_no_buffer_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (s.tx_ack && s.tx_st != F_IDLE && !tx_push) |=> $stable(s.tx_n))
        else $error("ack packet touched transmit buffer");
    buf_bound_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        s.tx_n <= 5'(BUF_DEPTH) && s.rx_n <= 5'(BUF_DEPTH))
        else $error("buffer count past depth");
    bus_wait_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (req && !s.ack_q) |-> (O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST))
        else $error("bus answer not after one wait cycle");
    crc_flag_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
        (s.rx_st == F_CRC && next_s.rx_st == F_IDLE && s.ctrl.crc_en
         && next_s.rx_fcs != s.crc_s && next_s.rx_fcs != s.crc_z) |=> s.stat[ST_CRCE])
        else $error("crc mismatch not flagged");
endmodule
`default_nettype wire

// file: test/rpfb_remote.sv
// Purpose: remote transceiver model on the symbol stream
// Assumes: one strobe per symbol towards the framer
// Notes:   keeps every symbol the framer sends
`timescale 1ns/1ps
`default_nettype none
module rpfb_remote (
    input  wire logic                  i_clock,
    input  wire rpfb_pkg::rpfb_txsym_s i_tx,
    output rpfb_pkg::rpfb_rxsym_s      o_rx
);
    import rpfb_pkg::*;
    rpfb_txsym_s seen[$];
    initial o_rx = '0;
    // capture what goes on air
    always @(posedge i_clock) begin
        if (i_tx.valid === 1'b1) seen.push_back(i_tx);
    end
    // idle data is inverted so a stale byte never passes for a new one
    task automatic send(input logic sop, input logic [7:0] d);
        @(posedge i_clock) o_rx <= '{valid: 1'b1, sop: sop, data: d};
        @(posedge i_clock) o_rx <= '{valid: 1'b0, sop: 1'b0, data: ~d};
        repeat (6) @(posedge i_clock);
    endtask
endmodule
`default_nettype wire

// file: test/test_radio_packet_framer_buffers.sv
// Purpose: self-checking bench of the framer and buffers
// Assumes: short symbol times through the tick parameters
// Notes:   serial select toggled once, serial data pin idle
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin failures++; \
    $display("unexpected %s expected %h seen %h", n, e, v); end end
module test_radio_packet_framer_buffers;
    import rpfb_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wq, moe, room, rdy, busy;
    logic        ss_n = 1'b1, coe;
    logic [4:0]  adr = '0;
    logic [31:0] wdat = '0, rdat, q;
    rpfb_txsym_s txs;
    rpfb_rxsym_s rxs;
    int          failures = 0, check_count = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////////////////
    rpfb_framer #(.GFSK_TICKS(8), .PN32_TICKS(16), .PN64_TICKS(32)) u_dut (
        .I_CLOCK(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(4'hF),
        .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wq), .I_SS_N(ss_n), .I_SPI_DOUT(1'b0),
        .O_MISO(), .O_MISO_OE(moe), .O_CLKOUT(), .O_CLKOUT_OE(coe), .O_TX_SYM(txs),
        .I_RX_SYM(rxs), .O_TX_ROOM(room), .O_RX_READY(rdy), .O_TX_BUSY(busy));
    rpfb_remote u_remote (.i_clock(clk), .i_tx(txs), .o_rx(rxs));
    // clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin failures++; summarize(); end
    end
    ////////////////////////////////////////////////////////////////////////////
    // usb crc16, msb first; the length byte is covered too
    function automatic logic [15:0] crc(input logic [15:0] s, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) s = {s[14:0], 1'b0} ^ ((s[15] ^ b[i]) ? 16'h8005 : 16'h0);
        return s;
    endfunction
    // one avalon cycle; request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        rd <= ~w; wr <= w; adr <= a; wdat <= d;
        do @(posedge clk); while (wq !== 1'b0);
        q = rdat;
        rd <= 1'b0; wr <= 1'b0;
    endtask
    task automatic t_reset;
        bus(0, REG_CTRL, 0);   `CHK("ctrl", 32'h0, q)
        bus(0, REG_STATUS, 0); `CHK("status", 32'h0, q)
        bus(0, 5'h1C, 0);      `CHK("unmapped", 32'h0, q)
        `CHK("miso_oe", 1'b0, moe)
        `CHK("tx_room", 1'b1, room)
        `CHK("clkout_oe", 1'b1, coe)
        @(posedge clk) ss_n <= 1'b0;
        @(posedge clk) `CHK("miso_oe_sel", 1'b1, moe)
        ss_n <= 1'b1;
        $display("test reset done");
    endtask
    // burst load, go, then compare every symbol that left
    task automatic t_tx(input logic [15:0] ctl, input logic [15:0] s, input logic [7:0] b[$]);
        logic [7:0] e[$];
        e = {8'h0, 8'h0, 8'(b.size())};
        foreach (b[i]) e.push_back(b[i]);
        foreach (e[i]) if (i > 1) s = crc(s, e[i]);
        e.push_back(s[15:8]); e.push_back(s[7:0]);
        u_remote.seen.delete();
        bus(1, REG_CTRL, ctl); bus(1, REG_SEED, 32'h1234); bus(1, REG_TXLEN, b.size());
        foreach (b[i]) bus(1, REG_TXDATA, b[i]);
        bus(1, REG_GO, 1);
        for (int i = 0; i < 2000 && (busy !== 1'b0 || u_remote.seen.size() == 0); i++) @(posedge clk);
        // the last symbol is captured one edge after busy falls
        repeat (2) @(posedge clk);
        `CHK("sym_count", 7 + b.size() - 2, u_remote.seen.size())
        foreach (u_remote.seen[i]) begin
            `CHK("sop", i < 2, u_remote.seen[i].sop)
            `CHK("spread", ctl[1], u_remote.seen[i].spread)
            `CHK("pn64", (i < 2) ? ctl[14] : ctl[2], u_remote.seen[i].pn64)
            if (i > 1) `CHK("sym_data", e[i], u_remote.seen[i].data)
        end
        $display("test tx done");
    endtask
    // framed packet in with auto ack on; flags, ack packet and drained bytes checked
    task automatic t_rx(input logic bad);
        logic [15:0] s, k;
        s = crc(crc(crc(16'h1234, 8'h02), 8'hA5), 8'h3C) ^ {15'h0, bad};
        k = 16'h0000;
        u_remote.seen.delete();
        bus(1, REG_CTRL, 32'h0028); bus(1, REG_STATUS, 7);
        u_remote.send(1, 0); u_remote.send(1, 0); u_remote.send(0, 8'h02);
        u_remote.send(0, 8'hA5); u_remote.send(0, 8'h3C);
        u_remote.send(0, s[15:8]); u_remote.send(0, s[7:0]);
        // let any ack packet finish before the buffers are inspected
        repeat (60) @(posedge clk);
        bus(0, REG_STATUS, 0);
        `CHK("rx_flags", {bad, 1'b1}, q[1:0])
        `CHK("rx_count", 5'd2, q[16:12])
        `CHK("tx_count", 5'd0, q[8:4])
        `CHK("rx_ready", 1'b1, rdy)
        `CHK("ack_syms", bad ? 0 : 5, u_remote.seen.size())
        if (!bad) k = {u_remote.seen[3].data, u_remote.seen[4].data};
        if (!bad) `CHK("ack_len", 8'h00, u_remote.seen[2].data)
        if (!bad) `CHK("ack_crc", crc(16'h1234, 8'h00), k)
        bus(0, REG_RXDATA, 0); `CHK("rx_b0", 8'hA5, q[7:0])
        bus(0, REG_RXDATA, 0); `CHK("rx_b1", 8'h3C, q[7:0])
        $display("test rx done");
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_tx(16'h0008, 16'h1234, '{8'h11, 8'h22});
        t_tx(16'h4018, 16'h0000, '{8'h5A});
        t_tx(16'h000E, 16'h1234, '{8'h00, 8'hFF});
        t_rx(1'b0);
        t_rx(1'b1);
        summarize();
    end
endmodule
`default_nettype wire
